// ### sim/dacs_chk_properties.sv
// port assertions of the active-channel status block
`timescale 1ns/1ps
module dacs_chk(input wire clk_i,sys_rst_i,reg_rd_i,grant_i,beat_i,
	input wire fetch_valid_i,wb_req_o,wb_done_i,input wire [7:0] reg_addr_i,
	input wire [31:0] reg_rdata_o,input wire [4:0] grant_idx_i,
	input wire [15:0] fetch_count_i,input wire [3:0] level_req_i);
default clocking @(posedge clk_i); endclocking
default disable iff (sys_rst_i);
wire rd=reg_rd_i&&reg_addr_i==8'h30;
chk_wb_hold: assert property(wb_req_o&&!wb_done_i|=>wb_req_o)
	else $error("wb dropped");
chk_wb_cause: assert property($rose(wb_req_o)|->$past(grant_i))
	else $error("wb no grant");
chk_busy_clr: assert property(wb_req_o&&wb_done_i&&!fetch_valid_i ##1
	rd&&!fetch_valid_i|=>!reg_rdata_o[15]) else $error("busy stuck");
chk_busy_set: assert property(fetch_valid_i ##1 rd&&!wb_done_i
	|=>reg_rdata_o[15]) else $error("busy unset");
chk_count_load: assert property(fetch_valid_i&&!beat_i ##1 rd&&!beat_i
	|=>reg_rdata_o[31:16]==$past(fetch_count_i,2)) else $error("count");
chk_index_load: assert property(grant_i ##1 rd&&!grant_i
	|=>reg_rdata_o[12:8]==$past(grant_idx_i,2)) else $error("index");
chk_quiet_bus: assert property(!rd|=>reg_rdata_o==32'h0)
	else $error("rdata");
chk_level_flags: assert property(rd&&$stable(level_req_i)
	|=>reg_rdata_o[3:0]==$past(level_req_i)) else $error("levels");
endmodule
bind dacs_active_status dacs_chk dacs_chk_inst(.*);

// ### sim/dacs_wb_model.sv
// write-back memory model: acknowledges a write-back after a short wait
`timescale 1ns/1ps
module dacs_wb_model(input wire clk_i,sys_rst_i,wb_req_o,output reg wb_done_i);
reg [1:0] wait_ff;
always @(posedge clk_i or posedge sys_rst_i)
	if (sys_rst_i) {wait_ff,wb_done_i}<=0;
	else begin
	wait_ff<=(wb_req_o&&!wb_done_i)?wait_ff+2'h1:2'h0;
	wb_done_i<=wait_ff==2'h2;
	end
endmodule

// ### sim/tb_top.sv
// self-checking bench of the active-channel status block
`timescale 1ns/1ps
module tb_top;
reg clk_i=0,sys_rst_i=1,reg_wr_i=0,reg_rd_i=0,grant_i=0,beat_i=0;
reg fetch_valid_i=0;
reg [7:0] reg_addr_i=0;
reg [31:0] reg_wdata_i=0,d;
reg [4:0] grant_idx_i=0;
reg [15:0] fetch_count_i=0;
reg [3:0] level_req_i=0;
wire [31:0] reg_rdata_o;
wire wb_req_o,wb_done_i;
wire [4:0] wb_idx_o;
wire [15:0] wb_count_o;
integer num_errors=0,total_checks=0,cyc=0,i;
dacs_active_status dacs_active_status_inst(.*);
dacs_wb_model dacs_wb_model_inst(.*);
always #2 clk_i=~clk_i;
always @(posedge clk_i) begin
	cyc<=cyc+1;
	if (cyc==3000) begin num_errors++; end_of_test; end
end
task chk(input [31:0] s,e,input string n);
	total_checks++;
	if (s!==e) begin
	num_errors++;
	$display("CHECK FAILED %s exp %h got %h",n,e,s);
	end
endtask
// every pulse input ends at the read's launch edge
task rd(input [7:0] a);
	@(posedge clk_i) {reg_rd_i,reg_addr_i,reg_wr_i,grant_i}<={1'b1,a,2'b0};
	{fetch_valid_i,beat_i}<=0;
	@(posedge clk_i) reg_rd_i<=0;
	#1 d=reg_rdata_o;
endtask
task t_reg;
	rd(8'h30); chk(d,0,"rst");
	@(posedge clk_i) {reg_wr_i,reg_wdata_i}<={1'b1,32'hFFFFFFFF};
	rd(8'h30); chk(d,0,"wr");
	rd(8'h34); chk(d,0,"unmap");
endtask
task t_fetch;
	@(posedge clk_i) {fetch_valid_i,fetch_count_i}<={1'b1,16'hBEEF};
	rd(8'h30); chk(d,32'hBEEF8000,"load");
	@(posedge clk_i) beat_i<=1;
	rd(8'h30); chk(d,32'hBEEE8000,"beat");
	for (i=0;i<16;i++) begin
	@(posedge clk_i) level_req_i<=i[3:0];
	rd(8'h30); chk(d&32'hF,i,"lvl");
	end
	level_req_i<=0;
endtask
task t_grant;
	@(posedge clk_i) {grant_i,grant_idx_i}<={1'b1,5'h13};
	rd(8'h30); chk(d,32'hBEEE9300,"grant");
	chk({wb_req_o,wb_idx_o,wb_count_o},{1'b1,5'h0,16'hBEEE},"wb");
	repeat (9) if (!wb_done_i) @(negedge clk_i);
	// count undefined once idle, so only the low half is judged
	rd(8'h30); chk(d&32'hFFFF,32'h1300,"idle");
	@(posedge clk_i) {grant_i,grant_idx_i}<={1'b1,5'h07};
	rd(8'h30); chk(d&32'hFFFF,32'h0700,"regrant");
	chk(wb_req_o,0,"nowb");
endtask
// beat stops at zero, then a fetch lands on the write-back completion edge
task t_edge;
	@(posedge clk_i) {fetch_valid_i,fetch_count_i}<={1'b1,16'h0001};
	rd(8'h30); chk(d,32'h00018700,"one");
	@(posedge clk_i) beat_i<=1;
	rd(8'h30); chk(d,32'h00008700,"zero");
	@(posedge clk_i) beat_i<=1;
	rd(8'h30); chk(d,32'h00008700,"floor");
	@(posedge clk_i) {grant_i,grant_idx_i}<={1'b1,5'h02};
	@(posedge clk_i) grant_i<=0;
	#1 chk({wb_req_o,wb_idx_o,wb_count_o},{1'b1,5'h07,16'h0},"wb0");
	repeat (2) @(posedge clk_i);
	@(posedge clk_i) {fetch_valid_i,fetch_count_i}<={1'b1,16'h1234};
	#1 chk(wb_done_i,1,"done");
	rd(8'h30); chk(d,32'h12348200,"setwin");
	@(posedge clk_i) sys_rst_i<=1;
	repeat (2) @(posedge clk_i);
	sys_rst_i<=0;
	rd(8'h30); chk(d,0,"rerst");
	chk({wb_req_o,wb_idx_o,wb_count_o},0,"wbrst");
endtask
task end_of_test;
	$display("checks %0d errors %0d",total_checks,num_errors);
	if (num_errors==0&&total_checks>0) $display("Regression OK");
	else $display("Regression broken");
	$finish;
endtask
initial begin
	repeat (5) @(posedge clk_i);
	sys_rst_i<=0;
	t_reg; t_fetch; t_grant; t_edge; end_of_test;
end
endmodule

// ### src/dacs_active_status.v
// active-channel status logic: transfer count, busy flag, channel index, level flags
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`include "dacs_defs.vh"

// Behaviour
// - hold 16-bit block count in bits 31:16
// - write held count back on new grant while busy flag set
// - count meaningful only while busy flag set
// - clear busy flag when write-back completes
// - set busy flag when next count read
// - channel index bits 12:8, updated each grant
// - per-level flag while request executing or pending
module dacs_active_status #(
	parameter CNT_W = 16,
	parameter IDX_W = 5,
	parameter LVLS = 4,
	parameter ADDR_W = 8
) (
	input wire clk_i,
	input wire sys_rst_i,
	// register port
	input wire [ADDR_W-1:0] reg_addr_i,
	input wire [31:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	output wire [31:0] reg_rdata_o,
	// arbiter grant
	input wire grant_i,
	input wire [IDX_W-1:0] grant_idx_i,
	// descriptor count fetched from write-back memory
	input wire fetch_valid_i,
	input wire [CNT_W-1:0] fetch_count_i,
	// running transfer decrements the count per beat
	input wire beat_i,
	// write-back memory port
	output wire wb_req_o,
	output wire [IDX_W-1:0] wb_idx_o,
	output wire [CNT_W-1:0] wb_count_o,
	input wire wb_done_i,
	// per-level executing or pending requests
	input wire [LVLS-1:0] level_req_i
);

////////////////////////////////////////////////////////////////////////////////

reg [CNT_W-1:0] block_count_field_ff;
reg [CNT_W-1:0] nxt_block_count_field;
reg active_busy_flag_ff;
reg nxt_active_busy_flag;
reg [IDX_W-1:0] active_channel_index_ff;
reg [LVLS-1:0] level_executing_flags_ff;
reg wb_pend_ff;
reg [IDX_W-1:0] wb_idx_ff;
reg [CNT_W-1:0] wb_count_ff;
reg [31:0] rdata_ff;
wire [31:0] status_word;

////////////////////////////////////////////////////////////////////////////////
// count and busy flag

always @* begin
	nxt_block_count_field = block_count_field_ff;
	nxt_active_busy_flag = active_busy_flag_ff;
	// the count stops at zero; a stray beat must not wrap it to all ones
	if (beat_i && active_busy_flag_ff &&
		block_count_field_ff != {CNT_W{1'b0}})
		nxt_block_count_field = block_count_field_ff - 1'b1;
	// write-back completion clears; a fetch in the same cycle wins
	if (wb_done_i && wb_pend_ff)
		nxt_active_busy_flag = 1'b0;
	if (fetch_valid_i) begin
		nxt_block_count_field = fetch_count_i;
		nxt_active_busy_flag = 1'b1;
	end
end

always @(posedge clk_i or posedge sys_rst_i) begin
	if (sys_rst_i) begin
		block_count_field_ff <= {CNT_W{1'b0}};
		active_busy_flag_ff <= 1'b0;
		active_channel_index_ff <= {IDX_W{1'b0}};
	end else begin
		block_count_field_ff <= nxt_block_count_field;
		active_busy_flag_ff <= nxt_active_busy_flag;
		if (grant_i)
			active_channel_index_ff <= grant_idx_i;
	end
end

////////////////////////////////////////////////////////////////////////////////
// one flag per priority level, following its request a cycle later

genvar lvl;
generate
	for (lvl = 0; lvl < LVLS; lvl = lvl + 1) begin : g_level
		always @(posedge clk_i or posedge sys_rst_i) begin
			if (sys_rst_i) begin
				level_executing_flags_ff[lvl] <= 1'b0;
			end else begin
				level_executing_flags_ff[lvl] <= level_req_i[lvl];
			end
		end
	end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// write-back of the held count on each new grant that arrives while the busy flag is set

// snapshot taken at the grant so a fetch right after cannot corrupt it
always @(posedge clk_i or posedge sys_rst_i) begin
	if (sys_rst_i) begin
		wb_pend_ff <= 1'b0;
		wb_idx_ff <= {IDX_W{1'b0}};
		wb_count_ff <= {CNT_W{1'b0}};
	end else begin
		if (grant_i && active_busy_flag_ff) begin
			wb_pend_ff <= 1'b1;
			wb_idx_ff <= active_channel_index_ff;
			wb_count_ff <= block_count_field_ff;
		end else if (wb_done_i) begin
			wb_pend_ff <= 1'b0;
		end
	end
end

assign wb_req_o = wb_pend_ff;
assign wb_idx_o = wb_idx_ff;
assign wb_count_o = wb_count_ff;

////////////////////////////////////////////////////////////////////////////////
// register read; writes are ignored

// count is shown raw; software must check the busy flag first
// each field placed by its own position; the gaps between them read zero
assign status_word[`DACS_CNT_MSB:`DACS_CNT_LSB] = block_count_field_ff;
assign status_word[`DACS_BUSY_BIT] = active_busy_flag_ff;
assign status_word[14:13] = 2'h0;
assign status_word[`DACS_IDX_MSB:`DACS_IDX_LSB] =
	active_channel_index_ff;
assign status_word[7:4] = 4'h0;
assign status_word[`DACS_LVL_MSB:`DACS_LVL_LSB] =
	level_executing_flags_ff;

always @(posedge clk_i or posedge sys_rst_i) begin
	if (sys_rst_i)
		rdata_ff <= `DACS_RESET_VALUE;
	else if (reg_rd_i && reg_addr_i == `DACS_ACTIVE_OFFSET)
		rdata_ff <= status_word;
	else
		rdata_ff <= 32'h00000000;
end

assign reg_rdata_o = rdata_ff;

endmodule

// ### src/dacs_defs.vh
// register offsets, field positions and reset values of the active-channel status block
`ifndef DACS_DEFS_VH
`define DACS_DEFS_VH
`define DACS_ACTIVE_OFFSET 8'h30
`define DACS_CNT_MSB 31
`define DACS_CNT_LSB 16
`define DACS_BUSY_BIT 15
`define DACS_IDX_MSB 12
`define DACS_IDX_LSB 8
`define DACS_LVL_MSB 3
`define DACS_LVL_LSB 0
`define DACS_RESET_VALUE 32'h00000000
`endif
